// >>> sfrb_cfg.svh
// Purpose: Offsets, field positions, reset values for the special-function bank
// Assumes: Byte-wide registers on a plain address/strobe port
// Notes: Included by the package, the bank and the core model
`ifndef SFRB_CFG_SVH
`define SFRB_CFG_SVH
`define SFRB_ADDR_W 4
`define SFRB_OFS_IE1 4'h0
`define SFRB_OFS_IE2 4'h1
`define SFRB_OFS_IRQ_FLAG_ONE 4'h2
`define SFRB_OFS_IRQ_FLAG_TWO 4'h3
`define SFRB_OFS_ME1 4'h4
`define SFRB_OFS_STAT 4'h8
`define SFRB_OFS_MASK 4'h9
`define SFRB_BIT_TX 7
`define SFRB_BIT_RX 6
`define SFRB_BIT_ACCV 5
`define SFRB_BIT_NMI 4
`define SFRB_BIT_OF 1
`define SFRB_BIT_WD 0
`define SFRB_BIT_PT 7
`define SFRB_IE1_IMPL 8'hf3
`define SFRB_IE2_IMPL 8'h80
`define SFRB_IRQ_FLAG_ONE_IMPL 8'hd3
`define SFRB_IRQ_FLAG_TWO_IMPL 8'h80
`define SFRB_ME1_IMPL 8'hc0
`define SFRB_IRQ_FLAG_ONE_RST 8'h82
`define SFRB_NSRC 7
`endif

// >>> sfrb_pkg.sv
// Purpose: Types for the special-function bank
// Assumes: sfrb_cfg.svh supplies the numbers
// Notes: State struct holds every flip-flop of the bank
`include "sfrb_cfg.svh"
package sfrb_pkg;
  typedef logic [7:0] sfrb_byte_t;
  typedef logic [`SFRB_NSRC-1:0] sfrb_src_t;
  typedef struct packed {
    sfrb_byte_t ie1;      // Enable byte one
    sfrb_byte_t ie2;      // Enable byte two
    sfrb_byte_t irq_flag_one;     // Flag byte one
    sfrb_byte_t irq_flag_two;     // Flag byte two
    sfrb_byte_t me1;      // Module enable byte
    sfrb_src_t stat;      // Sticky request status
    sfrb_src_t mask;      // Status mask
    sfrb_byte_t rdata;    // Read data
    sfrb_src_t req;       // Request outputs
    logic irq;            // Summary interrupt
    logic nmi_s1;         // Pin sync stage one
    logic nmi_s2;         // Pin sync stage two
    logic nmi_s3;         // Edge history
  } sfrb_state_s;
endpackage : sfrb_pkg

// >>> sfrb_bank.sv
// Purpose: Special-function register bank: enables, flags, module enables
// Assumes: Single 100 MHz clock; reset_n_in is power-on, pwr_clr_in a synchronous clear
// Notes: Absent bits hold no storage and read zero
//
// Design decision made here: the plain strobed port.
`timescale 1ns/10ps
`include "sfrb_cfg.svh"
module sfrb_bank import sfrb_pkg::*; (
  input wire logic clk_in,                          // System clock
  input wire logic reset_n_in,                      // Power-on reset, async, active low
  input wire logic pwr_clr_in,                      // Power-up clear, synchronous
  input wire logic [`SFRB_ADDR_W-1:0] addr_in,      // Register address
  input wire logic [7:0] wdata_in,                  // Write data
  input wire logic wr_in,                           // Write strobe
  input wire logic rd_in,                           // Read strobe
  input wire logic nmi_pin_in,                      // Reset/nonmaskable pin, asynchronous
  input wire logic osc_fault_in,                    // Oscillator fault report
  input wire logic flash_violation_in,              // Flash violation pulse
  input wire logic wd_overflow_in,                  // Watchdog overflow pulse
  input wire logic wd_key_violation_in,             // Security key violation pulse
  input wire logic wd_interval_mode_in,             // Watchdog in interval timer mode
  input wire logic serial_tx_set_in,                // Serial transmit event
  input wire logic serial_rx_set_in,                // Serial receive event
  input wire logic periodic_timer_set_in,           // Periodic timer event
  output logic [7:0] rdata_out,                     // Read data, cycle after strobe
  output logic serial_async_tx_en_out,              // Module enable bit 7
  output logic serial_async_rx_en_out,              // Module enable bit 6 (shared)
  output logic [`SFRB_NSRC-1:0] req_out,            // Per-source requests
  output logic irq_out                              // Summary interrupt level
);

  sfrb_state_s q, d;        // Register set and next value
  sfrb_src_t req_c;         // Combined requests
  sfrb_byte_t wmask_c;      // Scratch write mask

  // Merge a write into implemented bits only
  function automatic sfrb_byte_t merge(input sfrb_byte_t old, input sfrb_byte_t wd, input sfrb_byte_t impl);
    merge = (old & ~impl) | (wd & impl);
  endfunction : merge

  // Address match for a write
  function automatic logic hit(input logic [`SFRB_ADDR_W-1:0] a, input logic [`SFRB_ADDR_W-1:0] o);
    hit = (a == o);
  endfunction : hit

  // Next-state logic
  always_comb begin
    d = q;
    wmask_c = 8'h00;
    // Pin synchroniser, stage one read only by stage two
    d.nmi_s1 = nmi_pin_in;
    d.nmi_s2 = q.nmi_s1;
    d.nmi_s3 = q.nmi_s2;
    // Software writes
    if (wr_in) begin
      if (hit(addr_in, `SFRB_OFS_IE1)) begin
        d.ie1 = merge(q.ie1, wdata_in, `SFRB_IE1_IMPL);
      end
      if (hit(addr_in, `SFRB_OFS_IE2)) begin
        d.ie2 = merge(q.ie2, wdata_in, `SFRB_IE2_IMPL);
      end
      if (hit(addr_in, `SFRB_OFS_IRQ_FLAG_ONE)) begin
        d.irq_flag_one = merge(q.irq_flag_one, wdata_in, `SFRB_IRQ_FLAG_ONE_IMPL);
      end
      if (hit(addr_in, `SFRB_OFS_IRQ_FLAG_TWO)) begin
        d.irq_flag_two = merge(q.irq_flag_two, wdata_in, `SFRB_IRQ_FLAG_TWO_IMPL);
      end
      if (hit(addr_in, `SFRB_OFS_ME1)) begin
        d.me1 = merge(q.me1, wdata_in, `SFRB_ME1_IMPL);
      end
      // Write one to clear status
      if (hit(addr_in, `SFRB_OFS_STAT)) begin
        d.stat = q.stat & ~wdata_in[`SFRB_NSRC-1:0];
      end
      // Mask register
      if (hit(addr_in, `SFRB_OFS_MASK)) begin
        d.mask = wdata_in[`SFRB_NSRC-1:0];
      end
    end
    // Hardware sets win over software clears
    // Pin rising event sets flag
    if (q.nmi_s2 && !q.nmi_s3) begin
      d.irq_flag_one[`SFRB_BIT_NMI] = 1'b1;
    end
    if (osc_fault_in) begin
      d.irq_flag_one[`SFRB_BIT_OF] = 1'b1;
    end
    // Overflow or key violation sets flag
    if ((wd_overflow_in && !wd_interval_mode_in) || wd_key_violation_in) begin
      d.irq_flag_one[`SFRB_BIT_WD] = 1'b1;
    end
    // Interval timer expiry also raises the watchdog flag
    if (wd_overflow_in && wd_interval_mode_in) begin
      d.irq_flag_one[`SFRB_BIT_WD] = 1'b1;
    end
    // Serial events
    if (serial_tx_set_in) begin
      d.irq_flag_one[`SFRB_BIT_TX] = 1'b1;
    end
    if (serial_rx_set_in) begin
      d.irq_flag_one[`SFRB_BIT_RX] = 1'b1;
    end
    if (periodic_timer_set_in) begin
      d.irq_flag_two[`SFRB_BIT_PT] = 1'b1;
    end
    // Request terms from flags and enables
    req_c[0] = q.irq_flag_one[`SFRB_BIT_TX] & q.ie1[`SFRB_BIT_TX];
    req_c[1] = q.irq_flag_one[`SFRB_BIT_RX] & q.ie1[`SFRB_BIT_RX];
    // Flash violation masked only by its own enable
    req_c[2] = flash_violation_in & q.ie1[`SFRB_BIT_ACCV];
    req_c[3] = q.irq_flag_one[`SFRB_BIT_NMI] & q.ie1[`SFRB_BIT_NMI];
    req_c[4] = q.irq_flag_one[`SFRB_BIT_OF] & q.ie1[`SFRB_BIT_OF];
    // Watchdog enable only counts in interval mode
    req_c[5] = q.irq_flag_one[`SFRB_BIT_WD] & q.ie1[`SFRB_BIT_WD] & wd_interval_mode_in;
    req_c[6] = q.irq_flag_two[`SFRB_BIT_PT] & q.ie2[`SFRB_BIT_PT];
    d.req = req_c;
    // Sticky status, set wins over clear
    d.stat = d.stat | req_c;
    d.irq = |(d.stat & q.mask);
    d.rdata = 8'h00;
    if (rd_in) begin
      unique case (addr_in)
        `SFRB_OFS_IE1: d.rdata = q.ie1 & `SFRB_IE1_IMPL;
        `SFRB_OFS_IE2: d.rdata = q.ie2 & `SFRB_IE2_IMPL;
        `SFRB_OFS_IRQ_FLAG_ONE: d.rdata = q.irq_flag_one & `SFRB_IRQ_FLAG_ONE_IMPL;
        `SFRB_OFS_IRQ_FLAG_TWO: d.rdata = q.irq_flag_two & `SFRB_IRQ_FLAG_TWO_IMPL;
        `SFRB_OFS_ME1: d.rdata = q.me1 & `SFRB_ME1_IMPL;
        `SFRB_OFS_STAT: d.rdata = {1'b0, q.stat};
        `SFRB_OFS_MASK: d.rdata = {1'b0, q.mask};
        // Unmapped offsets 5 to 7 and 10 to 15 read zero
        default: d.rdata = 8'h00;
      endcase
    end
    if (pwr_clr_in) begin
      d.ie1 = 8'h00;
      d.ie2 = 8'h00;
      d.irq_flag_two = 8'h00;
      d.me1 = 8'h00;
      // Watchdog flag kept across power-up clear
      wmask_c = `SFRB_IRQ_FLAG_ONE_RST;
      d.irq_flag_one = (q.irq_flag_one & 8'h01) | wmask_c;
      d.stat = '0;
      d.req = '0;
      d.irq = 1'b0;
    end
    d.ie1 = d.ie1 & `SFRB_IE1_IMPL;
    d.ie2 = d.ie2 & `SFRB_IE2_IMPL;
    d.irq_flag_one = d.irq_flag_one & `SFRB_IRQ_FLAG_ONE_IMPL;
    d.irq_flag_two = d.irq_flag_two & `SFRB_IRQ_FLAG_TWO_IMPL;
    d.me1 = d.me1 & `SFRB_ME1_IMPL;
  end

  // State register; power-on reset clears watchdog flag too
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      q <= '0;
      q.irq_flag_one <= `SFRB_IRQ_FLAG_ONE_RST;
    end else begin
      q <= d;
    end
  end

  // Outputs straight from flip-flops
  assign rdata_out = q.rdata;
  assign serial_async_tx_en_out = q.me1[`SFRB_BIT_TX];
  assign serial_async_rx_en_out = q.me1[`SFRB_BIT_RX];
  assign req_out = q.req;
  assign irq_out = q.irq;

  chk_wd_keep_clear: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (pwr_clr_in && !wd_overflow_in && !wd_key_violation_in && !(wr_in && addr_in == `SFRB_OFS_IRQ_FLAG_ONE))
    |=> q.irq_flag_one[`SFRB_BIT_WD] == $past(q.irq_flag_one[`SFRB_BIT_WD])) else $error("watchdog flag lost on clear");
  chk_clear_values: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    pwr_clr_in |=> (q.ie1 == 8'h00 && q.me1 == 8'h00 && q.irq_flag_one[7] && q.irq_flag_one[1] && !q.irq_flag_one[4]))
    else $error("power-up clear values wrong");
  chk_absent_zero: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    ((q.ie1 & ~`SFRB_IE1_IMPL) == 8'h00) && ((q.irq_flag_one & ~`SFRB_IRQ_FLAG_ONE_IMPL) == 8'h00)
    && (q.ie2[6:0] == 7'h00) && (q.me1[5:0] == 6'h00)) else $error("absent bit holds a one");
  chk_nmi_edge: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (q.nmi_s2 && !q.nmi_s3 && !pwr_clr_in) |=> q.irq_flag_one[`SFRB_BIT_NMI]) else $error("pin event not flagged");
  chk_osc_set: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (osc_fault_in && !pwr_clr_in) |=> q.irq_flag_one[`SFRB_BIT_OF]) else $error("oscillator flag not set");
  chk_wd_gate: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (!wd_interval_mode_in && !pwr_clr_in) |=> !req_out[5]) else $error("watchdog request in watchdog mode");
  // Transmit request follows flag and enable
  chk_tx_req: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    !pwr_clr_in |=> req_out[0] == ($past(q.irq_flag_one[7]) && $past(q.ie1[7]))) else $error("transmit request wrong");
  chk_unmapped_rd: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (rd_in && addr_in == 4'h5) |=> rdata_out == 8'h00) else $error("unmapped read not zero");
  chk_me_write: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (wr_in && addr_in == `SFRB_OFS_ME1 && !pwr_clr_in) |=> serial_async_tx_en_out == $past(wdata_in[7]))
    else $error("module enable write lost");

endmodule : sfrb_bank

// >>> sfrb_core_model.sv
// Purpose: Processor core model issuing byte cycles to the bank
// Assumes: Bank never stalls; read data stands only in the cycle after the strobe
// Notes: Every bus signal changes by non-blocking assignment after a rising edge
`timescale 1ns/10ps
`include "sfrb_cfg.svh"
module sfrb_core_model (
  input wire logic clk_in,                      // System clock
  input wire logic [7:0] rdata_in,              // Read data from the bank
  output logic [`SFRB_ADDR_W-1:0] addr_out,     // Register address
  output logic [7:0] wdata_out,                 // Write data
  output logic wr_out,                          // Write strobe
  output logic rd_out                           // Read strobe
);
  // Idle bus from time zero
  initial begin
    addr_out = 4'h0;
    wdata_out = 8'h00;
    wr_out = 1'b0;
    rd_out = 1'b0;
  end

  // One-cycle write; a gap edge follows so strobes never double up
  task automatic write_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_in);
    addr_out <= a;
    wdata_out <= d;
    wr_out <= 1'b1;
    @(posedge clk_in);
    wr_out <= 1'b0;
  endtask : write_reg

  // One-cycle read; data taken once the answering edge has settled
  task automatic read_reg(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk_in);
    addr_out <= a;
    rd_out <= 1'b1;
    @(posedge clk_in);
    rd_out <= 1'b0;
    #1 d = rdata_in;
  endtask : read_reg
endmodule : sfrb_core_model

// >>> sfrb_bank_tb.sv
// Purpose: Self-checking bench for the special-function bank
// Assumes: Core model drives the register port
// Notes: Expectations come from the register layout, not from the bank
`timescale 1ns/10ps
module sfrb_bank_tb;
  logic clk_in, reset_n_in, pwr_clr, nmi, osc, flv, wdo, wdk, wdi, txs, rxs, pts; // Bench-driven inputs
  logic [3:0] addr;             // Bus address
  logic [7:0] wdata, rdata, got; // Bus data
  logic wr, rd, txen, rxen, irq; // Strobes and bank outputs
  logic [6:0] req;              // Per-source requests
  int err_count, tests_run;     // Mismatch and comparison counts

  sfrb_core_model core (.clk_in(clk_in), .rdata_in(rdata), .addr_out(addr), .wdata_out(wdata),
    .wr_out(wr), .rd_out(rd));
  sfrb_bank dut (.clk_in(clk_in), .reset_n_in(reset_n_in), .pwr_clr_in(pwr_clr), .addr_in(addr),
    .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .nmi_pin_in(nmi), .osc_fault_in(osc),
    .flash_violation_in(flv), .wd_overflow_in(wdo), .wd_key_violation_in(wdk),
    .wd_interval_mode_in(wdi), .serial_tx_set_in(txs), .serial_rx_set_in(rxs),
    .periodic_timer_set_in(pts), .rdata_out(rdata), .serial_async_tx_en_out(txen),
    .serial_async_rx_en_out(rxen), .req_out(req), .irq_out(irq));

  // Free-running 100 MHz clock
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  // Byte compare, counted
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    tests_run++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk

  // Read a register and compare it
  task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
    core.read_reg(a, got);
    chk(got, e);
  endtask : rd_chk

  // Counts and verdict, then stop
  task automatic print_verdict;
    $display("errors=%0d checks=%0d", err_count, tests_run);
    if (err_count == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : print_verdict

  // Reset values of the five bytes at 0 to 4 and an unmapped place
  task automatic t_reset;
    rd_chk(4'h0, 8'h00);
    rd_chk(4'h1, 8'h00);
    rd_chk(4'h2, 8'h82);
    rd_chk(4'h3, 8'h00);
    rd_chk(4'h4, 8'h00);
    rd_chk(4'h5, 8'h00);
  endtask : t_reset

  // All ones written; only present bits stick
  task automatic t_rw;
    for (int i = 0; i < 6; i++) core.write_reg(i[3:0], 8'hff);
    rd_chk(4'h0, 8'hf3);
    rd_chk(4'h1, 8'h80);
    rd_chk(4'h2, 8'hd3);
    rd_chk(4'h3, 8'h80);
    rd_chk(4'h4, 8'hc0);
    rd_chk(4'h5, 8'h00);
    chk({6'h00, txen, rxen}, 8'h03);
  endtask : t_rw

  // Requests follow flag and enable; watchdog gated by mode
  task automatic t_req;
    repeat (3) @(posedge clk_in);
    chk({1'b0, req}, 8'h5b);
    wdi <= 1'b1;
    flv <= 1'b1;
    repeat (3) @(posedge clk_in);
    chk({1'b0, req}, 8'h7f);
    core.write_reg(4'h0, 8'he3);
    repeat (3) @(posedge clk_in);
    chk({1'b0, req}, 8'h77);
    flv <= 1'b0;
  endtask : t_req

  // Power-up clear spares the watchdog flag written in t_rw
  task automatic t_puc;
    @(posedge clk_in);
    pwr_clr <= 1'b1;
    @(posedge clk_in);
    pwr_clr <= 1'b0;
    rd_chk(4'h0, 8'h00);
    rd_chk(4'h2, 8'h83);
    rd_chk(4'h4, 8'h00);
  endtask : t_puc

  // Hardware events set their flags
  task automatic t_events;
    core.write_reg(4'h2, 8'h00);
    rd_chk(4'h2, 8'h00);
    @(posedge clk_in);
    osc <= 1'b1;
    nmi <= 1'b1;
    @(posedge clk_in);
    osc <= 1'b0;
    repeat (4) @(posedge clk_in);
    rd_chk(4'h2, 8'h12);
    @(posedge clk_in);
    {wdo, txs, rxs} <= 3'b111;
    @(posedge clk_in);
    {wdo, txs, rxs, nmi} <= 4'b0000;
    rd_chk(4'h2, 8'hd3);
  endtask : t_events

  // Sticky status, mask, write-one clear, level output
  task automatic t_irq;
    int n;
    n = 0;
    core.write_reg(4'h1, 8'h80);
    core.write_reg(4'h9, 8'h7f);
    core.write_reg(4'h8, 8'h7f);
    repeat (2) @(posedge clk_in);
    chk({7'h00, irq}, 8'h00);
    @(posedge clk_in);
    pts <= 1'b1;
    @(posedge clk_in);
    pts <= 1'b0;
    while (irq !== 1'b1 && n < 10) begin
      @(posedge clk_in);
      n++;
    end
    if (irq !== 1'b1) begin
      err_count++;
      return;
    end
    rd_chk(4'h8, 8'h40);
    core.write_reg(4'h9, 8'h00);
    repeat (2) @(posedge clk_in);
    chk({7'h00, irq}, 8'h00);
    core.write_reg(4'h3, 8'h00);
    core.write_reg(4'h8, 8'h40);
    rd_chk(4'h8, 8'h00);
  endtask : t_irq

  // Main sequence
  initial begin
    err_count = 0;
    tests_run = 0;
    {pwr_clr, nmi, osc, flv, wdo, wdk, wdi, txs, rxs, pts} = 10'h000;
    reset_n_in = 1'b0;
    repeat (8) @(posedge clk_in);
    reset_n_in <= 1'b1;
    t_reset();
    t_rw();
    t_req();
    t_puc();
    t_events();
    t_irq();
    print_verdict();
  end
endmodule : sfrb_bank_tb
